/* design/homing_defines.vh */
// Register offsets, field positions, reset values and widths for the homing sequencer.
`ifndef HOMING_DEFINES_VH
`define HOMING_DEFINES_VH
`define ADDR_W 4
`define REG_CMD 4'h0
`define REG_MODE 4'h1
`define REG_SEARCH_SPD 4'h2
`define REG_CALIB_SPD 4'h3
`define REG_STATUS 4'h4
`define REG_DISTANCE 4'h5
`define REG_POSITION 4'h6
`define REG_ENC_POS 4'h7
`define REG_CONFIG 4'h8
`define CMD_START 2'h1
`define CMD_STOP 2'h2
`define MODE_SWAP_BIT 6
`define MODE_INV_BIT 7
`define MODE_RESET 8'h01
`define SEARCH_SPD_RESET 16'h0100
`define CALIB_SPD_RESET 16'h0010
`define CFG_AUTOSTOP_L_BIT 0
`define CFG_AUTOSTOP_R_BIT 1
`define CFG_ENC_IF_BIT 2
`define VEL_W 16
`define POS_W 32
`define ACC_W 24
`endif

/* design/homing_search_sequencer.v */
// Reference search sequencer for one stepper axis with left, right and home switches.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "homing_defines.vh"
// How it works
// - Mode register base value 1..8 selects the search sequence.
// - State machine started, stopped and polled through the search command register.
// - Automatic end-switch stop enables are ignored while a search runs.
// - Move at search velocity until the target switch is first seen.
// - Creep off the switch, re-enter opposite way at calibration speed, use midpoint.
// - Mode 1 searches only the left end switch as reference.
// - Mode 65 uses the right end switch instead of the left.
// - Mode 2 finds right switch then left, left switch is zero.
// - Mode 2 stores microstep distance between the end switches.
// - Mode 66 finds left first, then right switch as zero.
// - Mode 3 finds right switch, then middle of left switch as zero.
// - Mode 3 stores span from right switch to left switch middle.
// - Mode 67 finds left first, then right switch middle as zero.
// - Mode 4 finds middle of left switch; 68 uses the right one.
// - Mode 5 seeks home moving negative, reverses at the left limit.
// - Mode 6 seeks home moving positive, reverses at the right limit.
// - Mode 7 seeks home positive, ignoring limits, zero at home middle.
// - Mode 8 seeks home negative, ignoring limits, zero at home middle.
// - Adding 128 to modes 5..8 inverts home switch polarity.
// - Completion clears the encoder position register.
// - Stop switch inputs are unused by the search while the encoder interface is enabled; the status register still reports them.
module homing_search_sequencer #(
  parameter VEL_W = `VEL_W,
  parameter POS_W = `POS_W,
  parameter ACC_W = `ACC_W
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Switch pins, active high
  input wire stop_left,
  input wire stop_right,
  input wire home_sw,
  // Encoder counts
  input wire enc_step,
  input wire enc_dir,
  // Motor step output
  output reg step,
  output reg dir,
  output reg moving
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_FIRST = 4'h1;
  localparam [3:0] S_SEEK = 4'h2;
  localparam [3:0] S_LEAVE = 4'h3;
  localparam [3:0] S_ENTER = 4'h4;
  localparam [3:0] S_CROSS = 4'h5;
  localparam [3:0] S_BACK = 4'h6;
  localparam [3:0] S_DONE = 4'h7;

  // Three-stage synchronisers; a change counts when stages two and three agree.
  reg [2:0] sl_s, sr_s, hs_s;
  reg sl_q, sr_q, hs_q;
  always @(posedge clock) begin
    if (rst) begin
      sl_s <= 3'h0;
      sr_s <= 3'h0;
      hs_s <= 3'h0;
      sl_q <= 1'b0;
      sr_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      sl_s <= {sl_s[1:0], stop_left};
      sr_s <= {sr_s[1:0], stop_right};
      hs_s <= {hs_s[1:0], home_sw};
      if (sl_s[1] == sl_s[2]) sl_q <= sl_s[2];
      if (sr_s[1] == sr_s[2]) sr_q <= sr_s[2];
      if (hs_s[1] == hs_s[2]) hs_q <= hs_s[2];
    end
  end

  // Registers.
  reg [7:0] mode_q;
  reg [VEL_W-1:0] search_spd_q, calib_spd_q;
  reg [2:0] cfg_q;
  reg [POS_W-1:0] pos_q, enc_q, dist_q, mark_q, edge_q, entry_q;
  reg [3:0] state_q;
  reg leg_q;
  reg done_q, abort_q;
  reg [ACC_W-1:0] acc_q;

  // Mode decode.
  wire [5:0] base_mode = mode_q[5:0];
  wire swap = mode_q[`MODE_SWAP_BIT];
  wire inv = mode_q[`MODE_INV_BIT];
  wire valid_mode = (base_mode >= 6'h01) && (base_mode <= 6'h08);
  wire home_mode = base_mode >= 6'h05;
  // With the encoder interface on, the stop inputs carry encoder lines and are masked.
  wire sl = sl_q & ~cfg_q[`CFG_ENC_IF_BIT];
  wire sr = sr_q & ~cfg_q[`CFG_ENC_IF_BIT];
  wire hs = hs_q ^ (inv & home_mode);
  // Reference switch for end-switch modes; the swap bit mirrors left and right.
  wire ref_sw = swap ? sr : sl;
  wire far_sw = swap ? sl : sr;
  // Direction towards the reference: 0 means negative (towards left).
  wire ref_dir = swap;
  wire two_sided = (base_mode == 6'h03) || (base_mode == 6'h04) || (base_mode >= 6'h07);

  function [POS_W-1:0] absdiff;
    input [POS_W-1:0] a;
    input [POS_W-1:0] b;
    begin
      absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
    end
  endfunction

  // Signed midpoint; an unsigned half of a negative span would send the axis far away.
  function [POS_W-1:0] midpoint;
    input [POS_W-1:0] a;
    input [POS_W-1:0] b;
    reg [POS_W:0] s;
    begin
      s = {a[POS_W-1], a} + {b[POS_W-1], b};
      midpoint = s[POS_W:1];
    end
  endfunction

  // Target for the current phase.
  reg target;
  always @* begin
    target = 1'b0;
    case (base_mode)
      6'h02, 6'h03: target = leg_q ? ref_sw : far_sw;
      6'h05, 6'h06, 6'h07, 6'h08: target = hs;
      default: target = ref_sw;
    endcase
  end

  // Step generator: phase accumulator adds the active speed each cycle.
  wire busy = (state_q != S_IDLE) && (state_q != S_DONE);
  wire fast = (state_q == S_FIRST) || (state_q == S_SEEK);
  wire [VEL_W-1:0] speed = fast ? search_spd_q : calib_spd_q;
  wire [ACC_W:0] acc_sum = {1'b0, acc_q} + {{(ACC_W+1-VEL_W){1'b0}}, speed};
  // No step on the arrival cycle, so the zeroed position and the motor stay in line.
  wire arrive = (state_q == S_BACK) && (pos_q == edge_q);
  wire step_now = busy && !arrive && acc_sum[ACC_W];

  // Sequencer.
  reg [3:0] state_d;
  always @(posedge clock) begin
    if (rst) begin
      state_q <= S_IDLE;
      leg_q <= 1'b0;
      dir <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      pos_q <= {POS_W{1'b0}};
      enc_q <= {POS_W{1'b0}};
      dist_q <= {POS_W{1'b0}};
      mark_q <= {POS_W{1'b0}};
      edge_q <= {POS_W{1'b0}};
      entry_q <= {POS_W{1'b0}};
      acc_q <= {ACC_W{1'b0}};
      step <= 1'b0;
      moving <= 1'b0;
    end else begin
      acc_q <= busy ? acc_sum[ACC_W-1:0] : {ACC_W{1'b0}};
      step <= step_now;
      moving <= busy;
      if (step_now)
        pos_q <= dir ? pos_q + 1'b1 : pos_q - 1'b1;
      if (enc_step)
        enc_q <= enc_dir ? enc_q + 1'b1 : enc_q - 1'b1;
      case (state_q)
        S_IDLE, S_DONE: begin
          if (wr && addr == `REG_CMD && wdata[1:0] == `CMD_START && valid_mode) begin
            state_q <= S_FIRST;
            leg_q <= 1'b0;
            done_q <= 1'b0;
            abort_q <= 1'b0;
            case (base_mode)
              6'h02, 6'h03: dir <= ~ref_dir;
              6'h05, 6'h08: dir <= 1'b0;
              6'h06, 6'h07: dir <= 1'b1;
              default: dir <= ref_dir;
            endcase
          end
        end
        S_FIRST: begin
          // Limits only turn the axis around in modes 5 and 6; 7 and 8 ignore them.
          if (target) begin
            if ((base_mode == 6'h02 || base_mode == 6'h03) && !leg_q) begin
              mark_q <= pos_q;
              leg_q <= 1'b1;
              dir <= ~dir;
            end else begin
              state_q <= S_LEAVE;
              dir <= ~dir;
            end
          end else if (base_mode == 6'h05 && sl) begin
            dir <= 1'b1;
          end else if (base_mode == 6'h06 && sr) begin
            dir <= 1'b0;
          end
        end
        S_LEAVE: begin
          // Creep until the switch releases, then turn back.
          if (!target) begin
            edge_q <= pos_q;
            dir <= ~dir;
            state_q <= S_ENTER;
          end
        end
        S_ENTER: begin
          if (target) begin
            edge_q <= midpoint(edge_q, pos_q);
            if (two_sided) begin
              // Kept apart from mark_q, which holds the far switch for the distance.
              entry_q <= pos_q;
              state_q <= S_CROSS;
            end else begin
              state_q <= S_BACK;
            end
          end
        end
        S_CROSS: begin
          // Run through the switch to find its far edge for the middle.
          if (!target) begin
            edge_q <= midpoint(entry_q, pos_q);
            dir <= ~dir;
            state_q <= S_BACK;
          end
        end
        S_BACK: begin
          // Travel back to the computed reference point.
          if (pos_q == edge_q)
            state_q <= S_DONE;
          else
            dir <= ($signed(edge_q) > $signed(pos_q));
        end
        default: state_q <= S_IDLE;
      endcase
      if (arrive) begin
        if (base_mode == 6'h02 || base_mode == 6'h03)
          dist_q <= absdiff(mark_q, pos_q);
        pos_q <= {POS_W{1'b0}};
        enc_q <= {POS_W{1'b0}};
        done_q <= 1'b1;
      end
      if (busy && wr && addr == `REG_CMD && wdata[1:0] == `CMD_STOP) begin
        state_q <= S_IDLE;
        abort_q <= 1'b1;
      end
      if (!busy && wr && addr == `REG_POSITION)
        pos_q <= wdata[POS_W-1:0];
      if (wr && addr == `REG_ENC_POS && !(state_q == S_BACK && pos_q == edge_q))
        enc_q <= wdata[POS_W-1:0];
    end
  end

  // Configuration registers. The auto-stop bits are stored but never reach the sequencer.
  always @(posedge clock) begin
    if (rst) begin
      mode_q <= `MODE_RESET;
      search_spd_q <= `SEARCH_SPD_RESET;
      calib_spd_q <= `CALIB_SPD_RESET;
      cfg_q <= 3'h0;
    end else if (wr) begin
      case (addr)
        `REG_MODE: if (!busy) mode_q <= wdata[7:0];
        `REG_SEARCH_SPD: search_spd_q <= wdata[VEL_W-1:0];
        `REG_CALIB_SPD: calib_spd_q <= wdata[VEL_W-1:0];
        `REG_CONFIG: cfg_q <= wdata[2:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Read port, data one cycle after the strobe; unmapped reads return zero.
  always @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `REG_CMD: rdata <= {29'h0, abort_q, done_q, busy};
        `REG_MODE: rdata <= {24'h0, mode_q};
        `REG_SEARCH_SPD: rdata <= {{(32-VEL_W){1'b0}}, search_spd_q};
        `REG_CALIB_SPD: rdata <= {{(32-VEL_W){1'b0}}, calib_spd_q};
        `REG_STATUS: rdata <= {25'h0, hs_q, sr_q, sl_q, state_q};
        `REG_DISTANCE: rdata <= dist_q;
        `REG_POSITION: rdata <= pos_q;
        `REG_ENC_POS: rdata <= enc_q;
        `REG_CONFIG: rdata <= {29'h0, cfg_q};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule // homing_search_sequencer

/* testbench/homing_monitor.sv */
// Port checks for the homing sequencer.
`timescale 1ns/1ps
`include "homing_defines.vh"
module homing_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Motor drive
  input wire logic step,
  input wire logic moving
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // The mode copy treats moving as busy, since mode writes are refused mid-search.
  logic [7:0] mode_q;
  wire mode_ok = (mode_q[5:0] >= 6'h01) && (mode_q[5:0] <= 6'h08);
  always @(posedge clock) begin
    if (rst) mode_q <= `MODE_RESET;
    else if (wr && addr == `REG_MODE && !moving) mode_q <= wdata[7:0];
  end
  sequence s_start;
    wr && addr == `REG_CMD && wdata[1:0] == `CMD_START && !moving;
  endsequence
  sequence s_stop;
    wr && addr == `REG_CMD && wdata[1:0] == `CMD_STOP;
  endsequence
  a_start_runs: assert property (s_start ##0 mode_ok |=> ##1 moving)
    else $error("valid start did not move");
  a_bad_mode_idle: assert property (s_start ##0 !mode_ok |=> !moving)
    else $error("invalid mode started");
  a_stop_halts: assert property (s_stop ##1 (!wr) [*2] |-> !moving && !step)
    else $error("stop did not halt");
  a_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data without read");
  a_status_spare: assert property (rd && addr == `REG_CMD |=> rdata[31:3] == 29'h0)
    else $error("status spare bits set");
  a_step_single: assert property (step |=> !step)
    else $error("step longer than one cycle");
  a_idle_still: assert property (!moving && !$past(moving) |-> !step)
    else $error("step while idle");
  a_release_quiet: assert property ($fell(rst) |-> !moving && !step && rdata == 32'h0)
    else $error("outputs busy after reset");
endmodule // homing_monitor
bind homing_search_sequencer homing_monitor mon (.clock(clock), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .step(step), .moving(moving));

/* testbench/axis_model.sv */
// Stepper axis model with three eight-step switch windows and an encoder echo.
`timescale 1ns/1ps
module axis_model #(
  parameter integer LEFT_AT = 20,
  parameter integer HOME_AT = 120,
  parameter integer RIGHT_AT = 220
) (
  // Clock and motor drive
  input wire clock,
  input wire step,
  input wire dir,
  // Switches and encoder
  output reg stop_left = 1'b0,
  output reg stop_right = 1'b0,
  output reg home_sw = 1'b0,
  output wire enc_step,
  output wire enc_dir
);
  // The encoder counts with the motor, with no lag behind the step pulse.
  assign enc_step = step;
  assign enc_dir = dir;
  // Finite windows let a switch be crossed, so both-sided searches find a middle.
  integer pos = 70;
  reg home_inv = 1'b0;
  always @(posedge clock) begin
    if (step) pos = dir ? pos + 1 : pos - 1;
    stop_left <= pos >= LEFT_AT && pos <= LEFT_AT + 7;
    stop_right <= pos >= RIGHT_AT && pos <= RIGHT_AT + 7;
    home_sw <= (pos >= HOME_AT && pos <= HOME_AT + 7) ^ home_inv;
  end
endmodule // axis_model

/* testbench/homing_search_sequencer_tb.sv */
// Register-level bench for the homing sequencer driving a stepper axis model.
`timescale 1ns/1ps
`include "homing_defines.vh"
module homing_search_sequencer_tb;
  localparam integer TOL = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, v;
  logic stop_left, stop_right, home_sw, enc_step, enc_dir, step, dir, moving;
  integer err_count = 0;
  integer total_checks = 0;
  integer i;
  logic [7:0] modes [13] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03, 8'h43, 8'h04, 8'h44,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h85};
  integer starts [13] = '{70, 70, 70, 70, 70, 70, 70, 70, 70, 170, 70, 170, 170};
  integer goals [13] = '{24, 224, 24, 224, 24, 224, 24, 224, 124, 124, 124, 124, 124};
  homing_search_sequencer #(.VEL_W(24)) DUT (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_left(stop_left),
    .stop_right(stop_right), .home_sw(home_sw), .enc_step(enc_step), .enc_dir(enc_dir),
    .step(step), .dir(dir), .moving(moving));
  axis_model mdl (.clock(clock), .step(step), .dir(dir), .stop_left(stop_left),
    .stop_right(stop_right), .home_sw(home_sw), .enc_step(enc_step), .enc_dir(enc_dir));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data are sampled just after the edge that loads them, clear of the next edge.
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks = total_checks + 1;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_count = err_count + 1;
      $display("BAD %0t got %0d wanted %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic expect_reg(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] got;
    rd_reg(a, got);
    cmp(got, e, e);
  endtask
  task automatic run_mode(input logic [7:0] m, input integer s);
    integer n;
    mdl.home_inv = m[`MODE_INV_BIT];
    mdl.pos = s;
    repeat (6) @(posedge clock);
    wr_reg(`REG_MODE, {24'h0, m});
    wr_reg(`REG_CMD, 32'h1);
    n = 0;
    v = 32'h1;
    while (v[0] !== 1'b0) begin
      rd_reg(`REG_CMD, v);
      n = n + 1;
      if (n > 10000) begin
        err_count = err_count + 1;
        $display("BAD %0t search never finished", $time);
        final_report();
      end
    end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    expect_reg(`REG_MODE, 32'h1);
    expect_reg(`REG_SEARCH_SPD, 32'h100);
    expect_reg(`REG_CALIB_SPD, 32'h10);
    expect_reg(`REG_CMD, 32'h0);
    expect_reg(4'hF, 32'h0);
    wr_reg(`REG_SEARCH_SPD, 32'h400000);
    wr_reg(`REG_CALIB_SPD, 32'h200000);
    wr_reg(`REG_CONFIG, 32'h3);
    wr_reg(`REG_MODE, 32'h0);
    wr_reg(`REG_CMD, 32'h1);
    expect_reg(`REG_CMD, 32'h0);
    wr_reg(`REG_MODE, 32'h1);
    mdl.pos = 170;
    wr_reg(`REG_CMD, 32'h1);
    repeat (40) @(posedge clock);
    wr_reg(`REG_MODE, 32'h2);
    wr_reg(`REG_CMD, 32'h2);
    expect_reg(`REG_CMD, 32'h4);
    expect_reg(`REG_MODE, 32'h1);
    for (i = 0; i < 13; i = i + 1) begin
      run_mode(modes[i], starts[i]);
      expect_reg(`REG_CMD, 32'h2);
      expect_reg(`REG_POSITION, 32'h0);
      expect_reg(`REG_ENC_POS, 32'h0);
      cmp(mdl.pos, goals[i] - TOL, goals[i] + TOL);
      if (i >= 2 && i <= 5) begin
        rd_reg(`REG_DISTANCE, v);
        cmp(v, 196 - TOL, 196 + TOL);
      end
    end
    final_report();
  end
endmodule // homing_search_sequencer_tb
